// *** foe_estimator.sv ***
// Rotor angle and speed estimator with byte-wide register port
//
// Added by the designer: the address-and-strobe port.
`timescale 1ns/10ps
`default_nettype none
module foe_estimator (
  input  wire logic        clk,
  input  wire logic        rst_n,
  input  wire logic [15:0] addr,
  input  wire logic [7:0]  wdata,
  input  wire logic        wr_stb,
  input  wire logic        rd_stb,
  output logic      [7:0]  rdata,
  input  wire logic        pwm_period_tick,
  input  wire logic        estimator_select,
  input  wire logic        forced_angle_enable,
  input  wire logic [15:0] angle_compensation,
  input  wire logic [15:0] current_alpha,
  input  wire logic [15:0] current_beta,
  input  wire logic [15:0] voltage_alpha,
  input  wire logic [15:0] voltage_beta,
  output logic      [15:0] output_angle,
  output logic             power_error
);

  // ----------------------------------------------------------------
  // Register port: byte staging and word commit
  // ----------------------------------------------------------------
  logic [7:0]  hi_stage_reg;
  logic        wr_hi;
  logic        wr_lo;
  logic [15:0] wr_word;
  logic [15:0] word_addr;

  assign word_addr = {addr[15:1], 1'b0};
  assign wr_hi     = wr_stb & ~addr[0];
  assign wr_lo     = wr_stb & addr[0];
  assign wr_word   = {hi_stage_reg, wdata};

  // A write of the high byte only stages it; the low byte commits both
  always_ff @(posedge clk) begin
    if (!rst_n) begin
      hi_stage_reg <= 8'h00;
    end else if (wr_hi) begin
      hi_stage_reg <= wdata;
    end
  end

  logic commit_ekp, commit_eki, commit_ksl, commit_kmin, commit_bmf;
  logic commit_olpf, commit_fbase, commit_facc, commit_fmin;
  logic commit_theta, commit_etheta, commit_speed;

  assign commit_ekp    = wr_lo && word_addr == foe_pkg::ADDR_ESTIMATOR_PROP_GAIN;
  assign commit_eki    = wr_lo && word_addr == foe_pkg::ADDR_ESTIMATOR_INTEGRAL_GAIN;
  assign commit_ksl    = wr_lo && word_addr == foe_pkg::ADDR_SLIDING_OR_PLL_KP;
  assign commit_kmin   = wr_lo && word_addr == foe_pkg::ADDR_BEMF_FILTER_MIN_OR_KI;
  assign commit_bmf    = wr_lo && word_addr == foe_pkg::ADDR_BEMF_FILTER_COEFF_BASE;
  assign commit_olpf   = wr_lo && word_addr == foe_pkg::ADDR_SPEED_FILTER_FACTOR;
  assign commit_fbase  = wr_lo && word_addr == foe_pkg::ADDR_ANGLE_INCREMENT_SCALE;
  assign commit_facc   = wr_lo && word_addr == foe_pkg::ADDR_FORCED_SPEED_INCREMENT;
  assign commit_fmin   = wr_lo && word_addr == foe_pkg::ADDR_FORCED_SPEED_MINIMUM;
  assign commit_theta  = wr_lo && word_addr == foe_pkg::ADDR_OUTPUT_ANGLE;
  assign commit_etheta = wr_lo && word_addr == foe_pkg::ADDR_RAW_ESTIMATOR_ANGLE;
  assign commit_speed  = wr_lo && word_addr == foe_pkg::ADDR_ESTIMATED_SPEED;

  // ----------------------------------------------------------------
  // Configuration registers
  // ----------------------------------------------------------------
  logic [15:0] estimator_prop_gain_reg;
  logic [15:0] estimator_integral_gain_reg;
  logic [15:0] sliding_or_pll_prop_gain_reg;
  logic [15:0] bemf_filter_min_or_pll_ki_reg;
  logic [15:0] bemf_filter_coeff_base_reg;
  logic [15:0] speed_filter_factor_reg;
  logic [15:0] angle_increment_scale_reg;
  logic [15:0] forced_speed_increment_reg;
  logic [15:0] forced_speed_minimum_reg;

  always_ff @(posedge clk) begin
    if (!rst_n) begin
      estimator_prop_gain_reg       <= foe_pkg::WORD_RESET;
      estimator_integral_gain_reg   <= foe_pkg::WORD_RESET;
      sliding_or_pll_prop_gain_reg  <= foe_pkg::WORD_RESET;
      bemf_filter_min_or_pll_ki_reg <= foe_pkg::WORD_RESET;
      bemf_filter_coeff_base_reg    <= foe_pkg::WORD_RESET;
      speed_filter_factor_reg       <= foe_pkg::WORD_RESET;
      angle_increment_scale_reg     <= foe_pkg::WORD_RESET;
      forced_speed_increment_reg    <= foe_pkg::WORD_RESET;
      forced_speed_minimum_reg      <= foe_pkg::WORD_RESET;
    end else begin
      if (commit_ekp)   estimator_prop_gain_reg       <= wr_word & foe_pkg::GAIN_MASK;
      if (commit_eki)   estimator_integral_gain_reg   <= wr_word & foe_pkg::GAIN_MASK;
      if (commit_ksl)   sliding_or_pll_prop_gain_reg  <= wr_word & foe_pkg::GAIN_MASK;
      if (commit_kmin)  bemf_filter_min_or_pll_ki_reg <= wr_word & foe_pkg::GAIN_MASK;
      if (commit_bmf)   bemf_filter_coeff_base_reg    <= wr_word;
      if (commit_olpf)  speed_filter_factor_reg       <= wr_word & foe_pkg::GAIN_MASK;
      if (commit_fbase) angle_increment_scale_reg     <= wr_word;
      if (commit_facc)  forced_speed_increment_reg    <= wr_word;
      if (commit_fmin)  forced_speed_minimum_reg      <= wr_word;
    end
  end

  // ----------------------------------------------------------------
  // Estimator arithmetic (combinational, sampled on the period tick)
  // ----------------------------------------------------------------
  logic signed [15:0] bemf_alpha_reg, bemf_beta_reg;
  logic signed [15:0] speed_reg, speed_filt_reg;
  logic signed [15:0] raw_angle_reg, output_angle_reg;
  logic signed [15:0] forced_angle_reg;
  logic signed [23:0] forced_speed_acc_reg;
  logic signed [31:0] pi_integ_reg;
  logic        [15:0] mag_sq_reg;
  logic signed [15:0] power_reg;

  logic signed [15:0] sliding_gain, bemf_filter_coeff_min;
  logic signed [15:0] tracking_loop_prop_gain, tracking_loop_integral_gain;
  assign sliding_gain                = estimator_select ? 16'sh0000 :
                                       sliding_or_pll_prop_gain_reg;
  assign tracking_loop_prop_gain     = estimator_select ? sliding_or_pll_prop_gain_reg :
                                       16'sh0000;
  assign bemf_filter_coeff_min       = estimator_select ? 16'sh0000 :
                                       bemf_filter_min_or_pll_ki_reg;
  assign tracking_loop_integral_gain = estimator_select ? bemf_filter_min_or_pll_ki_reg :
                                       16'sh0000;

  // Coefficient = base * speed (Q15), clamped from below by the minimum register when select is 0, at zero when select is 1
  logic signed [31:0] coeff_prod;
  logic signed [15:0] coeff_raw, bemf_filter_coeff;
  assign coeff_prod = $signed({1'b0, bemf_filter_coeff_base_reg[14:0]}) * speed_reg;
  assign coeff_raw  = coeff_prod[30:15];
  assign bemf_filter_coeff = (coeff_raw < bemf_filter_coeff_min) ?
                             bemf_filter_coeff_min : coeff_raw;

  // Back-EMF model: e = v - (current / 2) * sliding gain (Q15), then low-pass
  logic signed [16:0] ea_in, eb_in;
  logic signed [32:0] ea_step, eb_step;
  logic signed [15:0] ea_next, eb_next;
  assign ea_in   = 17'(voltage_alpha) - 17'(signed'(({current_alpha[15], current_alpha[15:1]} *
                   32'(sliding_gain)) >>> foe_pkg::Q15_SHIFT));
  assign eb_in   = 17'(voltage_beta) - 17'(signed'(({current_beta[15], current_beta[15:1]} *
                   32'(sliding_gain)) >>> foe_pkg::Q15_SHIFT));
  assign ea_step = 33'(ea_in - 17'(bemf_alpha_reg)) * 33'(bemf_filter_coeff);
  assign eb_step = 33'(eb_in - 17'(bemf_beta_reg)) * 33'(bemf_filter_coeff);
  assign ea_next = 16'(bemf_alpha_reg + 16'(ea_step >>> foe_pkg::Q15_SHIFT));
  assign eb_next = 16'(bemf_beta_reg + 16'(eb_step >>> foe_pkg::Q15_SHIFT));

  // Angle error of the tracking loop: back-EMF alpha times the sign of the raw angle, minus back-EMF beta
  logic signed [31:0] angle_err;
  logic signed [15:0] err16;
  logic signed [15:0] kp_eff;
  logic [4:0]         kp_shift;
  logic signed [31:0] p_term, i_step;
  logic signed [31:0] pi_integ_next;
  logic signed [15:0] speed_est;
  assign angle_err = 32'(bemf_alpha_reg) * 32'(signed'(raw_angle_reg[15] ? -16'sd1 : 16'sd1));
  assign err16     = angle_err[15:0] - bemf_beta_reg;
  assign kp_eff    = estimator_select ? tracking_loop_prop_gain : estimator_prop_gain_reg;
  assign kp_shift  = 5'(foe_pkg::Q12_SHIFT);
  assign p_term    = (32'(err16) * 32'(kp_eff)) >>> kp_shift;
  assign i_step    = (32'(err16) * 32'(estimator_select ? tracking_loop_integral_gain :
                      estimator_integral_gain_reg)) >>> foe_pkg::Q15_SHIFT;
  assign pi_integ_next = pi_integ_reg + i_step;
  assign speed_est = 16'(pi_integ_next + p_term);

  // First-order speed filter
  logic signed [32:0] filt_step;
  logic signed [15:0] speed_filt_next;
  assign filt_step = 33'(17'(speed_est) - 17'(speed_filt_reg)) *
                     33'($signed({1'b0, speed_filter_factor_reg}));
  assign speed_filt_next = 16'(speed_filt_reg + 16'(filt_step >>> foe_pkg::Q15_SHIFT));

  // Forced-angle start-up
  logic signed [23:0] forced_min24, forced_acc_next;
  logic               below_min, use_forced;
  assign forced_min24    = {forced_speed_minimum_reg, 8'h00};
  assign forced_acc_next = forced_speed_acc_reg +
                           $signed({8'h00, forced_speed_increment_reg});
  assign below_min  = $signed({speed_filt_next, 8'h00}) < forced_min24;
  assign use_forced = forced_angle_enable & below_min;

  // Angle increment: speed * scale / 32768
  logic signed [31:0] est_inc, forced_inc;
  logic signed [15:0] raw_next;
  assign est_inc    = (32'(speed_filt_next) * 32'($signed({1'b0, angle_increment_scale_reg})))
                      >>> foe_pkg::Q15_SHIFT;
  assign forced_inc = (32'(forced_acc_next[23:8]) *
                      32'($signed({1'b0, angle_increment_scale_reg}))) >>> foe_pkg::Q15_SHIFT;
  assign raw_next   = 16'(raw_angle_reg + 16'(est_inc));

  // Squared magnitude and power
  logic [31:0] sq_sum;
  logic signed [31:0] pow_full;
  assign sq_sum   = 32'(unsigned'(32'(ea_next) * 32'(ea_next)) >> 1) +
                    32'(unsigned'(32'(eb_next) * 32'(eb_next)) >> 1);
  // Ports are plain vectors: sign-extend explicitly, or power never goes negative
  assign pow_full = (32'($signed(voltage_alpha)) * 32'($signed(current_alpha)) +
                     32'($signed(voltage_beta)) * 32'($signed(current_beta)))
                    >>> foe_pkg::Q15_SHIFT;

  // ----------------------------------------------------------------
  // Result registers
  // ----------------------------------------------------------------
  always_ff @(posedge clk) begin
    if (!rst_n) begin
      bemf_alpha_reg       <= 16'sh0000;
      bemf_beta_reg        <= 16'sh0000;
      speed_reg            <= 16'sh0000;
      speed_filt_reg       <= 16'sh0000;
      raw_angle_reg        <= 16'sh0000;
      output_angle_reg     <= 16'sh0000;
      forced_angle_reg     <= 16'sh0000;
      forced_speed_acc_reg <= 24'sh000000;
      pi_integ_reg         <= 32'sh00000000;
      mag_sq_reg           <= 16'h0000;
      power_reg            <= 16'sh0000;
    end else if (commit_theta) begin
      output_angle_reg <= wr_word;
      forced_angle_reg <= wr_word;
    end else if (commit_etheta) begin
      raw_angle_reg <= wr_word;
    end else if (commit_speed) begin
      speed_reg      <= wr_word;
      speed_filt_reg <= wr_word;
    end else if (pwm_period_tick) begin
      bemf_alpha_reg <= ea_next;
      bemf_beta_reg  <= eb_next;
      pi_integ_reg   <= pi_integ_next;
      speed_filt_reg <= speed_filt_next;
      mag_sq_reg     <= {1'b0, sq_sum[30:16]};
      power_reg      <= pow_full[15:0];
      if (use_forced) begin
        forced_speed_acc_reg <= forced_acc_next;
        speed_reg            <= forced_acc_next[23:8];
        forced_angle_reg     <= 16'(forced_angle_reg + 16'(forced_inc));
        output_angle_reg     <= 16'(forced_angle_reg + 16'(forced_inc));
        raw_angle_reg        <= raw_next;
      end else begin
        forced_speed_acc_reg <= {speed_filt_next, 8'h00};
        speed_reg            <= speed_filt_next;
        raw_angle_reg        <= raw_next;
        forced_angle_reg     <= 16'(raw_next + angle_compensation);
        output_angle_reg     <= 16'(raw_next + angle_compensation);
      end
    end
  end

  assign output_angle = output_angle_reg;
  assign power_error  = power_reg[15];

  // ----------------------------------------------------------------
  // Read mux: data appears the cycle after the read strobe
  // ----------------------------------------------------------------
  logic [15:0] rd_word;
  always_comb begin
    case (word_addr)
      foe_pkg::ADDR_ESTIMATOR_PROP_GAIN:     rd_word = estimator_prop_gain_reg;
      foe_pkg::ADDR_ESTIMATOR_INTEGRAL_GAIN: rd_word = estimator_integral_gain_reg;
      foe_pkg::ADDR_SLIDING_OR_PLL_KP:       rd_word = sliding_or_pll_prop_gain_reg;
      foe_pkg::ADDR_BEMF_FILTER_MIN_OR_KI:   rd_word = bemf_filter_min_or_pll_ki_reg;
      foe_pkg::ADDR_BEMF_FILTER_COEFF_BASE:  rd_word = bemf_filter_coeff_base_reg;
      foe_pkg::ADDR_SPEED_FILTER_FACTOR:     rd_word = speed_filter_factor_reg;
      foe_pkg::ADDR_ANGLE_INCREMENT_SCALE:   rd_word = angle_increment_scale_reg;
      foe_pkg::ADDR_FORCED_SPEED_INCREMENT:  rd_word = forced_speed_increment_reg;
      foe_pkg::ADDR_FORCED_SPEED_MINIMUM:    rd_word = forced_speed_minimum_reg;
      foe_pkg::ADDR_OUTPUT_ANGLE:            rd_word = output_angle_reg;
      foe_pkg::ADDR_RAW_ESTIMATOR_ANGLE:     rd_word = raw_angle_reg;
      foe_pkg::ADDR_BEMF_ALPHA:              rd_word = bemf_alpha_reg;
      foe_pkg::ADDR_BEMF_BETA:               rd_word = bemf_beta_reg;
      foe_pkg::ADDR_ESTIMATED_SPEED:         rd_word = speed_reg;
      foe_pkg::ADDR_BEMF_MAG_SQUARED:        rd_word = mag_sq_reg;
      foe_pkg::ADDR_MOTOR_POWER:             rd_word = power_reg;
      default:                               rd_word = 16'h0000;
    endcase
  end

  always_ff @(posedge clk) begin
    if (!rst_n) begin
      rdata <= 8'h00;
    end else if (rd_stb) begin
      rdata <= addr[0] ? rd_word[7:0] : rd_word[15:8];
    end else begin
      rdata <= 8'h00;
    end
  end

endmodule
`default_nettype wire

// *** foe_pkg.sv ***
// Package: register map, field positions, reset values and widths of the estimator
package foe_pkg;
  // ----------------------------------------------------------------
  // Register byte addresses (high byte at even address, low at +1)
  // ----------------------------------------------------------------
  localparam logic [15:0] ADDR_ESTIMATOR_PROP_GAIN     = 16'h4074;
  localparam logic [15:0] ADDR_ESTIMATOR_INTEGRAL_GAIN = 16'h4076;
  localparam logic [15:0] ADDR_SLIDING_OR_PLL_KP       = 16'h4078;
  localparam logic [15:0] ADDR_BEMF_FILTER_MIN_OR_KI   = 16'h407A;
  localparam logic [15:0] ADDR_BEMF_FILTER_COEFF_BASE  = 16'h407C;
  localparam logic [15:0] ADDR_SPEED_FILTER_FACTOR     = 16'h407E;
  localparam logic [15:0] ADDR_ANGLE_INCREMENT_SCALE   = 16'h4080;
  localparam logic [15:0] ADDR_FORCED_SPEED_INCREMENT  = 16'h4082;
  localparam logic [15:0] ADDR_FORCED_SPEED_MINIMUM    = 16'h4084;
  localparam logic [15:0] ADDR_OUTPUT_ANGLE            = 16'h40CC;
  localparam logic [15:0] ADDR_RAW_ESTIMATOR_ANGLE     = 16'h40CE;
  localparam logic [15:0] ADDR_BEMF_ALPHA              = 16'h40D0;
  localparam logic [15:0] ADDR_BEMF_BETA               = 16'h40D2;
  localparam logic [15:0] ADDR_ESTIMATED_SPEED         = 16'h40D4;
  localparam logic [15:0] ADDR_BEMF_MAG_SQUARED        = 16'h40D6;
  localparam logic [15:0] ADDR_MOTOR_POWER             = 16'h40D8;

  // ----------------------------------------------------------------
  // Widths, field positions, reset values
  // ----------------------------------------------------------------
  localparam int          WORD_W        = 16;
  localparam int          ACC_W         = 24;
  localparam int          GAIN_MSB      = 15;
  localparam logic [15:0] GAIN_MASK     = 16'h7FFF;
  localparam logic [15:0] WORD_RESET    = 16'h0000;
  localparam int          Q12_SHIFT     = 12;
  localparam int          Q15_SHIFT     = 15;
  localparam int          ACC_EXT_BITS  = 8;
endpackage

// *** foe_estimator_sva.sv ***
// Checker: register-port and output-timing properties of the estimator
`timescale 1ns/10ps
`default_nettype none
module foe_estimator_chk (
  input  wire logic        clk,
  input  wire logic        rst_n,
  input  wire logic [15:0] addr,
  input  wire logic [7:0]  wdata,
  input  wire logic        wr_stb,
  input  wire logic        rd_stb,
  input  wire logic [7:0]  rdata,
  input  wire logic        pwm_period_tick,
  input  wire logic [15:0] output_angle,
  input  wire logic        power_error
);
  // ----------------------------------------------------------------
  // Decodes
  // ----------------------------------------------------------------
  wire logic gain_hi_rd;
  wire logic tick_near;
  assign gain_hi_rd = rd_stb && (addr == foe_pkg::ADDR_ESTIMATOR_PROP_GAIN
                      || addr == foe_pkg::ADDR_ESTIMATOR_INTEGRAL_GAIN
                      || addr == foe_pkg::ADDR_SLIDING_OR_PLL_KP
                      || addr == foe_pkg::ADDR_BEMF_FILTER_MIN_OR_KI
                      || addr == foe_pkg::ADDR_SPEED_FILTER_FACTOR);
  assign tick_near = pwm_period_tick;

  default clocking cb @(posedge clk); endclocking
  default disable iff (!rst_n);

  // ----------------------------------------------------------------
  // Properties
  // ----------------------------------------------------------------
  AST_RDATA_QUIET: assert property (!$past(rd_stb) |-> rdata == 8'h00)
    else $error("read data not zero outside the answer cycle");
  // Allow two cycles of pipeline between a cause and the visible angle
  AST_ANGLE_CAUSE: assert property ($changed(output_angle) |->
    $past(tick_near) || $past(tick_near, 2) || $past(wr_stb) || $past(wr_stb, 2))
    else $error("output angle moved without tick or write");
  AST_POWER_CAUSE: assert property ($changed(power_error) |->
    $past(tick_near) || $past(tick_near, 2))
    else $error("power error moved without a tick");
  AST_GAIN_MSB: assert property (gain_hi_rd |=> !rdata[7])
    else $error("gain register top bit read as one");
  AST_SQUARE_MSB: assert property (
    rd_stb && addr == foe_pkg::ADDR_BEMF_MAG_SQUARED |=> !rdata[7])
    else $error("magnitude top bit read as one");
  AST_ANGLE_WRITE: assert property (
    wr_stb && addr == (foe_pkg::ADDR_OUTPUT_ANGLE | 16'h0001)
    |=> output_angle[7:0] == $past(wdata))
    else $error("angle low byte write not seen on output");
  AST_HIGH_STAGE: assert property (
    wr_stb && !addr[0] && !tick_near && !$past(tick_near) && !$past(tick_near, 2)
    |=> $stable(output_angle))
    else $error("high byte write changed the output angle");
  AST_UNMAPPED_ZERO: assert property (rd_stb && addr < 16'h4074 |=> rdata == 8'h00)
    else $error("unmapped read returned nonzero");
  AST_POWER_SIGN: assert property (
    rd_stb && addr == foe_pkg::ADDR_MOTOR_POWER && !tick_near && !$past(tick_near)
    && !$past(tick_near, 2) |=> rdata[7] == power_error)
    else $error("power sign and error flag disagree");
endmodule

bind foe_estimator foe_estimator_chk foe_estimator_chk_i (
  .clk(clk), .rst_n(rst_n), .addr(addr), .wdata(wdata), .wr_stb(wr_stb),
  .rd_stb(rd_stb), .rdata(rdata), .pwm_period_tick(pwm_period_tick),
  .output_angle(output_angle), .power_error(power_error));
`default_nettype wire

// *** foe_estimator_test.sv ***
// Testbench: self-checking register and output test of the estimator
`timescale 1ns/10ps
`default_nettype none
module foe_estimator_test;
  logic        clk = 1'b0;
  logic        rst_n = 1'b0;
  logic [15:0] addr = 16'h0000;
  logic [7:0]  wdata = 8'h00;
  logic        wr_stb = 1'b0;
  logic        rd_stb = 1'b0;
  logic        tick = 1'b0;
  logic        sel = 1'b0;
  logic        force_en = 1'b0;
  logic [15:0] comp = 16'h0000;
  logic [15:0] ia = 16'h0000;
  logic [15:0] ib = 16'h0000;
  logic [15:0] va = 16'h0000;
  logic [15:0] vb = 16'h0000;
  logic [7:0]  rdata;
  logic [15:0] output_angle;
  logic        power_error;
  logic        rd_seen = 1'b0;
  logic [7:0]  exp_q[$];
  logic [7:0]  msk_q[$];
  int          n_errors = 0;
  int          n_tests = 0;
  localparam logic [15:0] REG_A [16] = '{16'h4074, 16'h4076, 16'h4078, 16'h407A,
    16'h407C, 16'h407E, 16'h4080, 16'h4082, 16'h4084, 16'h40CC, 16'h40CE,
    16'h40D0, 16'h40D2, 16'h40D4, 16'h40D6, 16'h40D8};
  // Writable bits; read-only results keep their reset value until a tick
  localparam logic [15:0] REG_M [16] = '{16'h7FFF, 16'h7FFF, 16'h7FFF, 16'h7FFF,
    16'hFFFF, 16'h7FFF, 16'hFFFF, 16'hFFFF, 16'hFFFF, 16'hFFFF, 16'hFFFF,
    16'h0000, 16'h0000, 16'hFFFF, 16'h0000, 16'h0000};

  foe_estimator foe_estimator_i (
    .clk(clk), .rst_n(rst_n), .addr(addr), .wdata(wdata), .wr_stb(wr_stb),
    .rd_stb(rd_stb), .rdata(rdata), .pwm_period_tick(tick), .estimator_select(sel),
    .forced_angle_enable(force_en), .angle_compensation(comp), .current_alpha(ia),
    .current_beta(ib), .voltage_alpha(va), .voltage_beta(vb),
    .output_angle(output_angle), .power_error(power_error));

  always #5 clk = ~clk;

  // ----------------------------------------------------------------
  // Bus tasks and compares
  // ----------------------------------------------------------------
  task automatic bus(input logic w, input logic r, input logic [15:0] a, input logic [7:0] d);
    addr <= a;
    wdata <= d;
    wr_stb <= w;
    rd_stb <= r;
    @(posedge clk);
  endtask
  task automatic wr16(input logic [15:0] a, input logic [15:0] v);
    bus(1'b1, 1'b0, a, v[15:8]);
    bus(1'b1, 1'b0, a | 16'h0001, v[7:0]);
    bus(1'b0, 1'b0, 16'h0000, 8'h00);
  endtask
  task automatic rd16(input logic [15:0] a, input logic [15:0] e, input logic [15:0] m);
    exp_q.push_back(e[15:8]);
    msk_q.push_back(m[15:8]);
    bus(1'b0, 1'b1, a, 8'h00);
    exp_q.push_back(e[7:0]);
    msk_q.push_back(m[7:0]);
    bus(1'b0, 1'b1, a | 16'h0001, 8'h00);
    bus(1'b0, 1'b0, 16'h0000, 8'h00);
  endtask
  task automatic chk16(input string nm, input logic [15:0] e, input logic [15:0] g);
    n_tests++;
    if (g !== e) begin
      n_errors++;
      $display("[FAIL] %s expected %h seen %h", nm, e, g);
    end
  endtask
  task automatic pulse_tick();
    tick <= 1'b1;
    @(posedge clk);
    tick <= 1'b0;
    repeat (4) @(posedge clk);
  endtask
  task automatic complete_run();
    $display("Comparisons %0d, mismatches %0d", n_tests, n_errors);
    if (n_errors == 0 && n_tests > 0)
      $display("[ PASS ]");
    else
      $display("[ FAIL ]");
    $finish;
  endtask

  // Read results are due in the cycle after the strobe; sample mid-cycle
  always @(posedge clk) rd_seen <= rd_stb;
  always @(negedge clk) begin
    if (rd_seen === 1'b1) begin
      if (exp_q.size() == 0) begin
        n_errors++;
        $display("[FAIL] rdata expected none seen %h", rdata);
      end else begin
        chk16("rdata", {8'h00, exp_q[0] & msk_q[0]}, {8'h00, rdata & msk_q[0]});
        void'(exp_q.pop_front());
        void'(msk_q.pop_front());
      end
    end
  end

  initial begin
    repeat (20000) @(posedge clk);
    n_errors++;
    $display("[FAIL] run expected end seen timeout");
    complete_run();
  end

  // ----------------------------------------------------------------
  // Main sequence
  // ----------------------------------------------------------------
  initial begin
    logic [15:0] v;
    logic [15:0] angles [3];
    int i;
    angles = '{16'h8000, 16'h7FFF, 16'h2000};
    void'($urandom(32'hB2D6));
    repeat (10) @(posedge clk);
    rst_n <= 1'b1;
    @(posedge clk);
    for (i = 0; i < 16; i++) rd16(REG_A[i], 16'h0000, 16'hFFFF);
    for (i = 0; i < 16; i++) begin
      sel <= 1'($urandom);
      v = 16'($urandom);
      wr16(REG_A[i], v);
      rd16(REG_A[i], v & REG_M[i], 16'hFFFF);
    end
    wr16(foe_pkg::ADDR_ANGLE_INCREMENT_SCALE, 16'h1357);
    bus(1'b1, 1'b0, foe_pkg::ADDR_ANGLE_INCREMENT_SCALE, 8'hAB);
    bus(1'b0, 1'b0, 16'h0000, 8'h00);
    rd16(foe_pkg::ADDR_ANGLE_INCREMENT_SCALE, 16'h1357, 16'hFFFF);
    bus(1'b1, 1'b0, foe_pkg::ADDR_ANGLE_INCREMENT_SCALE | 16'h0001, 8'hCD);
    rd16(foe_pkg::ADDR_ANGLE_INCREMENT_SCALE, 16'hABCD, 16'hFFFF);
    wr16(16'h4000, 16'hFFFF);
    rd16(16'h4000, 16'h0000, 16'hFFFF);
    rd16(16'h40DA, 16'h0000, 16'hFFFF);
    for (i = 0; i < 3; i++) begin
      wr16(foe_pkg::ADDR_OUTPUT_ANGLE, angles[i]);
      comp <= 16'($urandom);
      repeat (3) @(posedge clk);
      @(negedge clk);
      chk16("output_angle", angles[i], output_angle);
      @(posedge clk);
      rd16(foe_pkg::ADDR_OUTPUT_ANGLE, angles[i], 16'hFFFF);
    end
    va <= 16'h7FFF;
    ia <= 16'h8000;
    vb <= 16'h0000;
    ib <= 16'h0000;
    pulse_tick();
    @(negedge clk);
    chk16("power_error", 16'h0001, {15'h0000, power_error});
    @(posedge clk);
    rd16(foe_pkg::ADDR_MOTOR_POWER, 16'h8000, 16'h8000);
    ia <= 16'h7FFF;
    pulse_tick();
    @(negedge clk);
    chk16("power_error", 16'h0000, {15'h0000, power_error});
    @(posedge clk);
    rd16(foe_pkg::ADDR_MOTOR_POWER, 16'h0000, 16'h8000);
    for (i = 0; i < 6; i++) begin
      {ia, ib} <= 32'($urandom);
      {va, vb} <= 32'($urandom);
      force_en <= 1'($urandom);
      sel <= 1'($urandom);
      pulse_tick();
      rd16(foe_pkg::ADDR_BEMF_MAG_SQUARED, 16'h0000, 16'h8000);
      rd16(foe_pkg::ADDR_ESTIMATOR_PROP_GAIN, 16'h0000, 16'h8000);
    end
    for (i = 0; i < 20 && exp_q.size() > 0; i++) @(posedge clk);
    if (exp_q.size() > 0) begin
      n_errors++;
      $display("[FAIL] pending reads expected 0 seen %0d", exp_q.size());
    end
    complete_run();
  end
endmodule
`default_nettype wire
